// [logic/sess_pkg.sv]
// Constants, command codes and register map of the flash erase host controller
// How it works
// - Erase is six writes: unlock pair, 80, unlock pair, sector address with 30.
// - More sector writes with 30 fit the window; host spaces them under 50 us.
// - Hardware reset aborts erase; host reissues the sequence afterwards. The controller does not: software must write OP_ERASE again.
// - Suspend is B0 at the bank address, valid only during sector erase.
// - Resume is 30 at the bank address; repeats are ignored.
// - Bypass program is A0 at any address, then address and value.
// - Bypass exit is 90 at the bank address, then 00 anywhere.
// - Secured region entry is unlock pair then 88 at the first unlock address.
package sess_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ADDR_W = 21;
  // Bus cycle timing in clocks
  localparam int T_SETUP = 3;
  localparam int T_STROBE = 12;
  localparam int T_HOLD = 3;
  localparam int T_READ = 25;
  // Windows in microseconds and derived clocks
  localparam int WINDOW_US = 50;
  localparam int GAP_US = 40;
  localparam int SUSPEND_US = 20;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  // Command codes
  localparam logic [7:0] D_UNLK1 = 8'haa;
  localparam logic [7:0] D_UNLK2 = 8'h55;
  localparam logic [7:0] D_SETUP = 8'h80;
  localparam logic [7:0] D_ERASE = 8'h30;
  localparam logic [7:0] D_SUSP = 8'hb0;
  localparam logic [7:0] D_PROG = 8'ha0;
  localparam logic [7:0] D_BYP = 8'h20;
  localparam logic [7:0] D_BYPX = 8'h90;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [7:0] D_SECR = 8'h88;
  localparam logic [7:0] D_AUTO = 8'h90;
  localparam logic [7:0] D_RESET = 8'hf0;
  localparam logic [ADDR_W-1:0] A_W1 = 21'h000555;
  localparam logic [ADDR_W-1:0] A_W2 = 21'h0002aa;
  localparam logic [ADDR_W-1:0] A_B1 = 21'h000aaa;
  localparam logic [ADDR_W-1:0] A_B2 = 21'h000555;
  localparam logic [7:0] OFS_PROT_W = 8'h02;
  localparam logic [7:0] OFS_PROT_B = 8'h04;
  // APB register offsets
  localparam logic [7:0] R_CMD = 8'h00;
  localparam logic [7:0] R_ADDR = 8'h04;
  localparam logic [7:0] R_DATA = 8'h08;
  localparam logic [7:0] R_STAT = 8'h0c;
  localparam logic [7:0] R_RDATA = 8'h10;
  localparam logic [7:0] R_CFG = 8'h14;
  // Operation codes written to R_CMD
  localparam logic [3:0] OP_ERASE = 4'h1;
  localparam logic [3:0] OP_ADD = 4'h2;
  localparam logic [3:0] OP_SUSP = 4'h3;
  localparam logic [3:0] OP_RESUME = 4'h4;
  localparam logic [3:0] OP_BPROG = 4'h5;
  localparam logic [3:0] OP_BEXIT = 4'h6;
  localparam logic [3:0] OP_SECR = 4'h7;
  localparam logic [3:0] OP_AUTO = 4'h8;
  localparam logic [3:0] OP_READ = 4'h9;
  localparam logic [3:0] OP_PROT = 4'ha;
  localparam logic [3:0] OP_RESET = 4'hb;
  localparam logic [3:0] OP_BENTER = 4'hc;
  localparam logic [3:0] OP_PROG = 4'hd;
  typedef enum logic [1:0] {SESS_IDLE, SESS_SETUP, SESS_STROBE, SESS_HOLD} sess_cyc_e;
endpackage

// [logic/sess_bus_cycle.sv]
// One asynchronous write or read bus cycle on the flash pins
`timescale 1ns/1ps
module sess_bus_cycle
  import sess_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_read,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [15:0] data_in,
  output logic done,
  output logic [15:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire logic [15:0] flash_dq_in
);
  sess_cyc_e state;
  logic rd;
  logic [7:0] cnt;
  logic [15:0] s1, s2, s3;

  // Three stages; data taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 16'h0000;
      s2 <= 16'h0000;
      s3 <= 16'h0000;
    end else begin
      s1 <= flash_dq_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SESS_IDLE;
      cnt <= 8'h00;
      rd <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state)
        SESS_IDLE: begin
          if (start) begin
            rd <= is_read;
            flash_addr <= addr_in;
            flash_dq_out <= data_in;
            flash_dq_oe <= !is_read;
            flash_ce_n <= 1'b0;
            cnt <= 8'(T_SETUP);
            state <= SESS_SETUP;
          end
        end
        SESS_SETUP: begin
          if (cnt == 8'h00) begin
            flash_we_n <= rd;
            flash_oe_n <= !rd;
            cnt <= rd ? 8'(T_READ) : 8'(T_STROBE);
            state <= SESS_STROBE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        SESS_STROBE: begin
          if (cnt == 8'h00 && (!rd || s2 == s3)) begin
            // Rising strobe edge latches the command; window timing starts here
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            rdata <= s3;
            cnt <= 8'(T_HOLD);
            state <= SESS_HOLD;
          end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end
        end
        SESS_HOLD: begin
          if (cnt == 8'h00) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state <= SESS_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: state <= SESS_IDLE;
      endcase
    end
  end
endmodule // sess_bus_cycle

// [logic/sess_host.sv]
// Host controller that drives sector erase, suspend and related sequences
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module sess_host
  import sess_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int SUSP_CYCLES = SUSPEND_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  input wire logic ready_busy_in
);
  typedef enum logic [2:0] {H_IDLE, H_ISSUE, H_WAIT, H_GAP, H_SUSW} sess_host_e;
  sess_host_e state;
  logic [ADDR_W-1:0] op_addr;
  logic [15:0] op_data;
  logic [3:0] op;
  logic byte_mode;
  logic [2:0] step;
  logic [2:0] nsteps;
  logic busy;
  logic error;
  logic [15:0] rd_value;
  logic hw_reset;
  logic [31:0] timer;
  logic cyc_start, cyc_done;
  logic [15:0] cyc_rdata;
  logic [ADDR_W-1:0] seq_addr;
  logic [15:0] seq_data;
  logic seq_read;
  logic rb1, rb2, rb3, rb_stable;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign cyc_start = (state == H_ISSUE);

  // Length of each host operation in bus cycles
  function automatic logic [2:0] op_len(input logic [3:0] o);
    case (o)
      OP_ERASE: op_len = 3'd6;
      OP_ADD, OP_SUSP, OP_RESUME, OP_READ, OP_RESET: op_len = 3'd1;
      OP_BPROG, OP_BEXIT: op_len = 3'd2;
      OP_SECR, OP_AUTO, OP_BENTER: op_len = 3'd3;
      OP_PROT, OP_PROG: op_len = 3'd4;
      default: op_len = 3'd0;
    endcase
  endfunction

  // Unlock address for a step, picked by word or byte mode
  function automatic logic [ADDR_W-1:0] unlk(input logic second, input logic bm);
    unlk = second ? (bm ? A_B2 : A_W2) : (bm ? A_B1 : A_W1);
  endfunction

  // Address and data of the current step of the current operation
  always_comb begin
    seq_addr = op_addr;
    seq_data = 16'h0000;
    seq_read = 1'b0;
    case (op)
      OP_ERASE: begin
        case (step)
          3'd0, 3'd3: seq_addr = unlk(1'b0, byte_mode);
          3'd1, 3'd4: seq_addr = unlk(1'b1, byte_mode);
          3'd2: seq_addr = unlk(1'b0, byte_mode);
          default: seq_addr = op_addr;
        endcase
        case (step)
          3'd0, 3'd3: seq_data = {8'h00, D_UNLK1};
          3'd1, 3'd4: seq_data = {8'h00, D_UNLK2};
          3'd2: seq_data = {8'h00, D_SETUP};
          default: seq_data = {8'h00, D_ERASE};
        endcase
      end
      OP_ADD: seq_data = {8'h00, D_ERASE};
      OP_SUSP: seq_data = {8'h00, D_SUSP};
      OP_RESUME: seq_data = {8'h00, D_ERASE};
      OP_RESET: seq_data = {8'h00, D_RESET};
      OP_READ: seq_read = 1'b1;
      OP_BPROG: begin
        seq_data = (step == 3'd0) ? {8'h00, D_PROG} : op_data;
      end
      OP_BEXIT: seq_data = (step == 3'd0) ? {8'h00, D_BYPX} : {8'h00, D_ZERO};
      OP_SECR, OP_AUTO, OP_BENTER, OP_PROT, OP_PROG: begin
        if (step < 3'd2) begin
          seq_addr = unlk(step[0], byte_mode);
          seq_data = {8'h00, step[0] ? D_UNLK2 : D_UNLK1};
        end else if (step == 3'd2) begin
          seq_addr = (op == OP_SECR || op == OP_BENTER || op == OP_PROG) ?
                     unlk(1'b0, byte_mode) : (op_addr | unlk(1'b0, byte_mode));
          seq_data = {8'h00, (op == OP_SECR) ? D_SECR : (op == OP_BENTER) ? D_BYP :
                     (op == OP_PROG) ? D_PROG : D_AUTO};
        end else if (op == OP_PROT) begin
          seq_addr = {op_addr[ADDR_W-1:8], byte_mode ? OFS_PROT_B : OFS_PROT_W};
          seq_read = 1'b1;
        end else begin
          seq_data = op_data;
        end
      end
      default: seq_data = 16'h0000;
    endcase
  end

  // Ready/busy pin from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb1 <= 1'b1;
      rb2 <= 1'b1;
      rb3 <= 1'b1;
      rb_stable <= 1'b1;
    end else begin
      rb1 <= ready_busy_in;
      rb2 <= rb1;
      rb3 <= rb2;
      if (rb2 == rb3) begin
        rb_stable <= rb3;
      end
    end
  end

  // APB writes load the operation; a command while busy is flagged and dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_addr <= '0;
      op_data <= 16'h0000;
      byte_mode <= 1'b0;
      hw_reset <= 1'b0;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        R_ADDR: op_addr <= pwdata[ADDR_W-1:0];
        R_DATA: op_data <= pwdata[15:0];
        R_CFG: begin
          byte_mode <= pwdata[0];
          hw_reset <= pwdata[1];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_reset_n <= 1'b0;
    end else begin
      flash_reset_n <= !hw_reset;
    end
  end

  // Sequencer over bus cycles and erase timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= H_IDLE;
      op <= 4'h0;
      step <= 3'd0;
      nsteps <= 3'd0;
      busy <= 1'b0;
      error <= 1'b0;
      timer <= 32'h0;
      rd_value <= 16'h0000;
    end else begin
      if (psel && penable && pwrite && paddr == R_CMD) begin
        if (busy || op_len(pwdata[3:0]) == 3'd0) begin
          error <= 1'b1;
        end else begin
          op <= pwdata[3:0];
          nsteps <= op_len(pwdata[3:0]);
          step <= 3'd0;
          busy <= 1'b1;
          state <= H_ISSUE;
        end
      end else if (psel && penable && pwrite && paddr == R_STAT) begin
        error <= error & !pwdata[1];
      end
      // Gap countdown comes first, so a fresh load in the case below wins
      if (state != H_SUSW && timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (state)
        H_IDLE: ;
        H_ISSUE: state <= H_WAIT;
        H_WAIT: begin
          if (cyc_done) begin
            if (seq_read) begin
              rd_value <= cyc_rdata;
            end
            if (step + 3'd1 < nsteps) begin
              step <= step + 3'd1;
              state <= H_ISSUE;
            end else if (op == OP_ERASE || op == OP_ADD) begin
              // Keep the next sector write well inside the device window
              timer <= 32'(GAP_CYCLES);
              state <= H_GAP;
            end else if (op == OP_SUSP) begin
              timer <= 32'(SUSP_CYCLES);
              state <= H_SUSW;
            end else begin
              busy <= 1'b0;
              state <= H_IDLE;
            end
          end
        end
        H_GAP: begin
          // Busy clears at once; the gap shows only as status bit2, so software may add sectors during it
          busy <= 1'b0;
          state <= H_IDLE;
        end
        H_SUSW: begin
          // Wait out the worst suspend latency before touching the bank
          if (timer == 32'h0) begin
            busy <= 1'b0;
            state <= H_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Status: bit0 busy, bit1 error, bit2 add window open, bit3 device busy
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      R_ADDR: prdata = {{(32-ADDR_W){1'b0}}, op_addr};
      R_DATA: prdata = {16'h0, op_data};
      R_STAT: prdata = {28'h0, !rb_stable, timer != 32'h0 && state != H_SUSW, error, busy};
      R_RDATA: prdata = {16'h0, rd_value}; // via read value
      R_CFG: prdata = {30'h0, hw_reset, byte_mode};
      default: prdata = 32'h0;
    endcase
  end

  sess_bus_cycle u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .is_read(seq_read),
    .addr_in(seq_addr),
    .data_in(seq_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_dq_in(flash_dq_in)
  );
endmodule // sess_host

// [tb/sess_checker.sv]
// Port checker for the flash erase host controller
`timescale 1ns/1ps
module sess_checker
  import sess_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  property p_hw_reset;
    acc && pwrite && paddr == R_CFG |-> ##2 flash_reset_n == !$past(pwdata[1], 2);
  endproperty
  a_zero_wait: assert property (acc |-> pready && !pslverr)
    else $error("access not answered at once");
  a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe without chip enable");
  a_no_contention: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
    else $error("read strobe while driving");
  a_we_drives: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("write strobe without data drive");
  a_strobe_width: assert property ($fell(flash_we_n) |-> ##12 !flash_we_n)
    else $error("write strobe too short");
  a_strobe_stable: assert property (!flash_we_n && $past(!flash_we_n)
      |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved under strobe");
  a_ce_setup: assert property ($fell(flash_we_n) |-> $past(!flash_ce_n, 2))
    else $error("chip enable setup missing");
  a_ce_release: assert property ($rose(flash_ce_n) |-> flash_we_n && flash_oe_n)
    else $error("chip enable dropped under strobe");
  a_hw_reset: assert property (p_hw_reset)
    else $error("hardware reset pin not following config");
  c_write: cover property ($fell(flash_we_n));
  c_read: cover property ($fell(flash_oe_n));
  c_cfg: cover property (acc && pwrite && paddr == R_CFG);
endmodule // sess_checker
bind sess_host sess_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n,
  .flash_oe_n, .flash_reset_n);

// [tb/sess_flash_model.sv]
// Behavioural flash device: command decode, erase window, suspend, status reads
`timescale 1ns/1ps
module sess_flash_model
  import sess_pkg::*;
#(
  parameter int WIN = 600,
  parameter int ERS = 1500
)(
  input wire logic pclk,
  input wire logic rst_n,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [20:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output logic rb
);
  typedef enum logic [1:0] {M_IDLE, M_WIN, M_ERS, M_SUSP} sess_mst_e;
  sess_mst_e st = M_IDLE;
  int tmr = 0;
  logic we_q = 1'b1;
  logic tog = 1'b0;
  logic auto_rd = 1'b0;
  logic [7:0] h[6];
  logic [15:0] last = 16'h0;
  logic [15:0] val;
  logic [20:0] wa[$];
  logic [15:0] wd[$];
  // pclk stands in for the device's own timer clock
  wire wr = we_n && !we_q && !ce_n;
  wire busy = st == M_WIN || st == M_ERS;
  always @(posedge pclk) begin
    we_q <= we_n;
    if (rst_n !== 1'b1) begin
      st <= M_IDLE;
      tmr <= 0;
      auto_rd <= 1'b0;
    end else if (wr) begin
      wa.push_back(addr);
      wd.push_back(din);
      for (int i = 5; i > 0; i--) h[i] <= h[i-1];
      h[0] <= din[7:0];
      // Autoselect entered by 90 right after an unlock write, left by the reset code
      if (din[7:0] == 8'h90 && h[0] == 8'h55) auto_rd <= 1'b1;
      else if (din[7:0] == 8'hf0) auto_rd <= 1'b0;
      tmr <= 0;
      case (st)
        M_IDLE: if ({h[4], h[3], h[2], h[1], h[0], din[7:0]} == 48'haa5580aa5530) st <= M_WIN;
        M_WIN: st <= din[7:0] == 8'h30 ? M_WIN : din[7:0] == 8'hb0 ? M_SUSP : M_IDLE;
        M_ERS: if (din[7:0] == 8'hb0) st <= M_SUSP;
        default: if (din[7:0] == 8'h30) st <= M_ERS;
      endcase
    end else begin
      tmr <= tmr + 1;
      if (st == M_WIN && tmr >= WIN) begin
        st <= M_ERS;
        tmr <= 0;
      end
      if (st == M_ERS && tmr >= ERS) st <= M_IDLE;
    end
    last <= dout;
  end
  always @(negedge oe_n) if (!ce_n && busy) tog <= ~tog;
  // Status on every read while not idle keeps the model small; array data otherwise
  // Address bit 12 stands in for the protection map of a sector
  assign val = st != M_IDLE ? {8'h00, st == M_SUSP, tog, 2'b00, st == M_ERS, 3'b000}
    : (auto_rd && addr[7:0] inside {8'h02, 8'h04}) ? {15'h0, addr[12]}
    : addr[15:0] ^ 16'h5a5a;
  // Released bus shows a changing pattern, never the last value
  assign dout = (!ce_n && !oe_n) ? val : ~last;
  assign rb = st == M_ERS ? 1'b0 : 1'b1;
endmodule // sess_flash_model

// [tb/tb.sv]
// Self-checking bench for the flash erase host controller
`timescale 1ns/1ps
module tb;
  import sess_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rb;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [20:0] fa;
  logic [15:0] fo, fi, md;
  logic oe, ce, we, re, frn, t6;
  int err_count = 0, checks = 0;
  logic [1:0] qm[$];
  logic [20:0] qa[$];
  logic [15:0] qd[$];
  logic [3:0] ops[13] = '{OP_ERASE, OP_ADD, OP_SUSP, OP_RESUME, OP_BENTER, OP_BPROG,
    OP_BEXIT, OP_SECR, OP_AUTO, OP_PROG, OP_RESET, OP_READ, OP_PROT};
  always #2 pclk = ~pclk;
  assign fi = oe ? fo : md;
  sess_host #(.GAP_CYCLES(50), .SUSP_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa), .flash_dq_out(fo),
    .flash_dq_oe(oe), .flash_dq_in(fi), .flash_ce_n(ce), .flash_we_n(we), .flash_oe_n(re),
    .flash_reset_n(frn), .ready_busy_in(rb));
  sess_flash_model i_dev (.pclk(pclk), .rst_n(frn), .ce_n(ce), .we_n(we), .oe_n(re),
    .addr(fa), .din(fo), .dout(md), .rb(rb));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    // Ready and read data are taken at the very edge that completes the access
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    if (pready !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic op(input logic [3:0] o);
    apb(1, R_CMD, {28'h0, o});
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(0, R_STAT, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    chk(rd[0], 0);
  endtask
  task automatic put(input logic [1:0] m, input logic [20:0] a, input logic [15:0] d);
    qm.push_back(m);
    qa.push_back(a);
    qd.push_back(d);
  endtask
  task automatic expect_seq(input logic [3:0] o, input logic b, input logic [20:0] a,
      input logic [15:0] d);
    logic [20:0] u1, u2;
    u1 = b ? 21'haaa : 21'h555;
    u2 = b ? 21'h555 : 21'h2aa;
    if (o inside {OP_ERASE, OP_SECR, OP_AUTO, OP_BENTER, OP_PROG, OP_PROT}) begin
      put(1, u1, 16'haa);
      put(1, u2, 16'h55);
    end
    case (o)
      OP_ERASE: begin
        put(1, u1, 16'h80);
        put(1, u1, 16'haa);
        put(1, u2, 16'h55);
        put(1, a, 16'h30);
      end
      OP_ADD, OP_RESUME: put(1, a, 16'h30);
      OP_SUSP: put(1, a, 16'hb0);
      OP_SECR: put(1, u1, 16'h88);
      OP_AUTO, OP_PROT: put(1, a | u1, 16'h90);
      OP_BENTER: put(1, u1, 16'h20);
      OP_PROG: begin
        put(1, u1, 16'ha0);
        put(3, a, d);
      end
      OP_BPROG: begin
        put(0, a, 16'ha0);
        put(3, a, d);
      end
      OP_BEXIT: begin
        put(1, a, 16'h90);
        put(0, a, 16'h00);
      end
      OP_RESET: put(0, a, 16'hf0);
      default: ;
    endcase
  endtask
  task automatic run(input logic [3:0] o, input logic b);
    logic [20:0] a;
    logic [15:0] d;
    a = 21'($urandom);
    d = 16'($urandom);
    qm = {};
    qa = {};
    qd = {};
    i_dev.wa = {};
    i_dev.wd = {};
    expect_seq(o, b, a, d);
    apb(1, R_ADDR, {11'h0, a});
    apb(1, R_DATA, {16'h0, d});
    apb(0, R_ADDR, 0);
    chk(rd, {11'h0, a});
    op(o);
    idle();
    chk(i_dev.wa.size(), qa.size());
    foreach (qa[i]) if (i < i_dev.wa.size()) begin
      chk(qm[i][1] ? i_dev.wd[i] : {8'h0, i_dev.wd[i][7:0]}, qd[i]);
      if (qm[i][0]) chk(i_dev.wa[i], qa[i]);
    end
    // Protection readback only means something while the bank reads array data
    if (o == OP_PROT && i_dev.st == 0) begin
      apb(0, R_RDATA, 0);
      chk(rd, {31'h0, a[12]});
    end
    $display("test op %h byte %0d done", o, b);
  endtask
  task automatic rdst();
    op(OP_READ);
    idle();
    apb(0, R_RDATA, 0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    int n;
    void'($urandom(32'h53a0));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    apb(0, R_STAT, 0);
    chk(rd[1:0], 0);
    chk({frn, ce, we, re}, 4'hf);
    for (int b = 0; b < 2; b++) begin
      apb(1, R_CFG, b);
      apb(0, R_CFG, 0);
      chk(rd, b);
      foreach (ops[i]) run(ops[i], b[0]);
      apb(1, R_CFG, 2);
      // Reset pin follows one edge later, the device one edge after that
      repeat (2) @(posedge pclk);
      chk(i_dev.st, 0);
    end
    apb(1, R_CFG, 0);
    @(posedge pclk);
    chk(frn, 1);
    run(OP_ERASE, 0);
    chk(i_dev.st, 1);
    apb(0, R_STAT, 0);
    chk(rd[2], 1);
    rdst();
    chk(rd[3], 0);
    n = 0;
    while (rb !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    // Let the pin pass the three-stage input filter
    repeat (4) @(posedge pclk);
    apb(0, R_STAT, 0);
    chk(rd[3], 1);
    rdst();
    chk({rd[7], rd[3]}, 2'b01);
    t6 = rd[6];
    rdst();
    chk(rd[6], !t6);
    run(OP_SUSP, 0);
    chk(i_dev.st, 3);
    apb(0, R_STAT, 0);
    chk(rd[3], 0);
    rdst();
    chk(rd[7], 1);
    t6 = rd[6];
    rdst();
    chk(rd[6], t6);
    run(OP_RESUME, 0);
    chk(i_dev.st, 2);
    op(OP_READ);
    op(OP_READ);
    apb(0, R_STAT, 0);
    chk(rd[1], 1);
    idle();
    apb(1, R_STAT, 2);
    apb(0, R_STAT, 0);
    chk(rd[1], 0);
    op(4'hf);
    apb(0, R_STAT, 0);
    chk(rd[1], 1);
    apb(1, R_STAT, 2);
    apb(1, R_CFG, 2);
    repeat (2) @(posedge pclk);
    chk({frn, 30'h0, i_dev.st == 0}, 1);
    apb(1, R_CFG, 0);
    run(OP_PROT, 1'b0);
    apb(1, 8'h40, 32'h1234);
    apb(0, 8'h40, 0);
    chk(rd, 0);
    $display("test erase flow done");
    give_verdict();
  end
endmodule // tb
